/* verilog/otm_defs.vh */
// Purpose: constants shared by the output terminal mapper
// Assumes: 32-bit apb data, byte offsets in paddr[7:0]
// Notes:   units: freq in 10 hz, analog in 0.1 %, delay in 0.1 s
`ifndef OTM_DEFS_VH
`define OTM_DEFS_VH
// ==========================================================
// register byte offsets
`define OTM_A_CTRL     8'h00
`define OTM_A_FSEL     8'h04
`define OTM_A_QSEL     8'h08
`define OTM_A_PMAX     8'h0c
`define OTM_A_AO1      8'h10
`define OTM_A_AO2      8'h14
`define OTM_A_DLY_DO1  8'h18
`define OTM_A_DLY_RLY  8'h1c
`define OTM_A_DLY_MUX  8'h20
`define OTM_A_POL      8'h24
`define OTM_A_TSET     8'h28
`define OTM_A_RTHR     8'h2c
`define OTM_A_AVILIM   8'h30
`define OTM_A_TTHR     8'h34
`define OTM_A_STAT     8'h38
// ==========================================================
// field positions
`define OTM_B_MODE     0
`define OTM_B_TEN      1
`define OTM_B_FS_DO1   0
`define OTM_B_FS_RLY   8
`define OTM_B_FS_MUX   16
`define OTM_B_QS_PLS   0
`define OTM_B_QS_AO1   8
`define OTM_B_QS_AO2   16
`define OTM_B_HI       16
`define OTM_B_F10      16
// ==========================================================
// function codes of the digital outputs
`define OTM_FC_TIMING  6'h1e
`define OTM_FC_AVILIM  6'h1f
`define OTM_FC_LDROP   6'h20
`define OTM_FC_REV     6'h21
`define OTM_FC_TEMP    6'h23
`define OTM_FC_LOWLIM  6'h25
`define OTM_FC_WARN    6'h26
`define OTM_FC_RUNT    6'h28
// quantity codes of pulse and analog outputs
`define OTM_Q_RUNF     4'h0
`define OTM_Q_SETF     4'h1
`define OTM_Q_CUR      4'h2
`define OTM_Q_TRQ      4'h3
`define OTM_Q_PWR      4'h4
`define OTM_Q_VOLT     4'h5
`define OTM_Q_LEN      4'ha
`define OTM_Q_CNT      4'hb
`define OTM_MODE_PULSE 1'b0
// ==========================================================
// reset values, limits, scaling
`define OTM_PMAX_RST   14'h1388
`define OTM_PMAX_MIN   14'h0001
`define OTM_PMAX_MAX   14'h2710
`define OTM_GAIN_RST   16'h0064
`define OTM_GAIN_DIV   32'sh00000064
`define OTM_PERMIL     10'h3e8
`define OTM_VOLT_NUM   19'h00006
`define OTM_VOLT_DEN   19'h00005
`define OTM_POL_D0     17'h00001
`define OTM_POL_D1     17'h0000a
`define OTM_POL_D4     17'h02710
`define OTM_POL_BASE   17'h0000a
`define OTM_POL_INV    4'h1
`define OTM_NCO_MUL    13'h10c7
`define OTM_NCO_SH     10
`define OTM_DIV_STEPS  5'h19
`define OTM_CLK_HZ     40000000
`define OTM_TICK_MS    100
`endif

/* verilog/otm_delay.v */
// Purpose: one output delay stage in 0.1 s ticks
// Assumes: tick is a one-cycle pulse from the same clock
// Notes:   a zero delay passes the state on the next edge
`timescale 1ns/1ps
`default_nettype none
module otm_delay (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // timebase and setting
  input  wire        tick,
  input  wire [15:0] dly,
  // state in and out
  input  wire        din,
  output reg         dout_ff
);
  // ========================================================
  // delay counter
  reg [15:0] cnt_ff;
  // a state that flips back before expiry clears the count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 16'h0000;
      dout_ff <= 1'b0;
    end else if (din == dout_ff) begin
      cnt_ff <= 16'h0000;
    end else if (cnt_ff >= dly) begin
      dout_ff <= din;
      cnt_ff  <= 16'h0000;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule // otm_delay
`default_nettype wire

/* verilog/otm_top.v */
// Purpose: programmable output terminals of a drive
// Assumes: status inputs come from drive-core logic on pclk
// Notes:   analog outputs are commands in 0.1 % (1000 = 10 v)
//
// Summary of operation
// - code 30: run time reached timing set
// - code 31: analog input one outside limits
// - code 32: load dropped
// - code 33: motor running in reverse
// - code 35: heatsink reached threshold temperature
// - code 37: lower limit reached, or stopped
// - code 38: fault with keep-running handling
// - code 40: run time exceeds threshold
// - mode 0 pulse, mode 1 switch
// - switch mode uses function code selection
// - pulse maximum settable 0.01 to 100 khz
// - maximum is full scale, resets 50 khz
// - frequencies scale to max output frequency
// - current, torque, power scale to double rated
// - voltage scales to 1.2 times rated
// - length and count scale to maxima
// - analog command is gain times value plus offset
// - offset of 100 % means 10 v
// - separate delay for each switched terminal
// - polarity digits: ones, tens, ten-thousands
// - digit 0: closed when active
// - digit 1: open when active
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "otm_defs.vh"
module otm_top #(
  parameter TICK_CYC = `OTM_CLK_HZ / 1000 * `OTM_TICK_MS
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_ff,
  output reg         pready_ff,
  output reg         pslverr_ff,
  // drive-core status
  input  wire [15:0] run_time,
  input  wire [15:0] analog_input_one,
  input  wire        load_drop,
  input  wire        reverse_run,
  input  wire [15:0] heatsink_temp,
  input  wire        drive_running,
  input  wire        fault_keep_run,
  input  wire [15:0] run_freq,
  input  wire [15:0] set_freq,
  input  wire [15:0] lower_limit_freq,
  input  wire [15:0] max_freq,
  // drive-core quantities and their references
  input  wire [15:0] out_current,
  input  wire [15:0] rated_current,
  input  wire [15:0] out_torque,
  input  wire [15:0] rated_torque,
  input  wire [15:0] out_power,
  input  wire [15:0] rated_power,
  input  wire [15:0] out_voltage,
  input  wire [15:0] rated_voltage,
  input  wire [15:0] length_meas,
  input  wire [15:0] length_max,
  input  wire [15:0] count_val,
  input  wire [15:0] count_max,
  // terminals, high = contact closed
  output reg         first_digital_output_ff,
  output reg         main_relay_output_ff,
  output reg         multiplexed_output_terminal_ff,
  output reg  [9:0]  analog_output_one_ff,
  output reg  [9:0]  analog_output_two_ff
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_RUN  = 2'b01;
  // ========================================================
  // configuration registers
  reg        mode_ff;
  reg        timing_en_ff;
  reg [5:0]  fs_do1_ff;
  reg [5:0]  fs_rly_ff;
  reg [5:0]  fs_mux_ff;
  reg [3:0]  qs_pls_ff;
  reg [3:0]  qs_ao1_ff;
  reg [3:0]  qs_ao2_ff;
  reg [13:0] pmax_ff;
  reg [15:0] gain1_ff;
  reg [15:0] off1_ff;
  reg [15:0] gain2_ff;
  reg [15:0] off2_ff;
  reg [15:0] dly_do1_ff;
  reg [15:0] dly_rly_ff;
  reg [15:0] dly_mux_ff;
  reg [16:0] pol_ff;
  reg [15:0] tset_ff;
  reg [15:0] rthr_ff;
  reg [15:0] avi_lo_ff;
  reg [15:0] avi_hi_ff;
  reg [15:0] tthr_ff;
  // ========================================================
  // functions
  // condition selected by a digital function code
  function otm_cond;
    input [5:0] fc;
    begin
      case (fc)
        `OTM_FC_TIMING: otm_cond = timing_en_ff & (run_time >= tset_ff);
        `OTM_FC_AVILIM: otm_cond = (analog_input_one > avi_hi_ff) |
                                   (analog_input_one < avi_lo_ff);
        `OTM_FC_LDROP:  otm_cond = load_drop;
        `OTM_FC_REV:    otm_cond = reverse_run;
        `OTM_FC_TEMP:   otm_cond = heatsink_temp >= tthr_ff;
        `OTM_FC_LOWLIM: otm_cond = ~drive_running | (run_freq <= lower_limit_freq);
        `OTM_FC_WARN:   otm_cond = fault_keep_run;
        `OTM_FC_RUNT:   otm_cond = run_time > rthr_ff;
        default:        otm_cond = 1'b0;
      endcase
    end
  endfunction
  // {full scale, value} of a quantity code
  function [32:0] otm_quant;
    input [3:0] qs;
    reg   [18:0] v12;
    begin
      v12 = ({3'h0, rated_voltage} * `OTM_VOLT_NUM) / `OTM_VOLT_DEN;
      case (qs)
        `OTM_Q_RUNF: otm_quant = {1'b0, max_freq, run_freq};
        `OTM_Q_SETF: otm_quant = {1'b0, max_freq, set_freq};
        `OTM_Q_CUR:  otm_quant = {rated_current, 1'b0, out_current};
        `OTM_Q_TRQ:  otm_quant = {rated_torque, 1'b0, out_torque};
        `OTM_Q_PWR:  otm_quant = {rated_power, 1'b0, out_power};
        `OTM_Q_VOLT: otm_quant = {v12[16:0], out_voltage};
        `OTM_Q_LEN:  otm_quant = {1'b0, length_max, length_meas};
        `OTM_Q_CNT:  otm_quant = {1'b0, count_max, count_val};
        default:     otm_quant = 33'h000000000;
      endcase
    end
  endfunction
  // corrected analog command y = k*x + b, clamped to 0..100 %
  function [9:0] otm_scale;
    input [9:0]  x;
    input [15:0] k;
    input [15:0] b;
    reg signed [31:0] t;
    begin
      t = ($signed(k) * $signed({22'h000000, x})) / `OTM_GAIN_DIV;
      t = t + $signed(b);
      if (t < 0)
        otm_scale = 10'h000;
      else if (t > $signed({22'h000000, `OTM_PERMIL}))
        otm_scale = `OTM_PERMIL;
      else
        otm_scale = t[9:0];
    end
  endfunction
  // polarity digit set means the contact opens when active
  function otm_inv;
    input [16:0] div;
    reg   [16:0] d;
    begin
      d = (pol_ff / div) % `OTM_POL_BASE;
      otm_inv = (d[3:0] == `OTM_POL_INV);
    end
  endfunction
  // ========================================================
  // apb decode
  wire setup = psel & ~penable;
  wire wr    = psel & penable & pwrite & pready_ff;
  reg  [31:0] rd_data;
  reg         rd_hit;
  reg  [13:0] f10_ff;
  wire        d_do1;
  wire        d_rly;
  wire        d_mux;
  reg         c_do1_ff;
  reg         c_rly_ff;
  reg         c_mux_ff;
  // read mux, unmapped offsets answer zero with an error
  always @* begin
    rd_hit  = 1'b1;
    rd_data = 32'h00000000;
    case (paddr)
      `OTM_A_CTRL:    rd_data = {30'h0, timing_en_ff, mode_ff};
      `OTM_A_FSEL:    rd_data = {10'h0, fs_mux_ff, 2'h0, fs_rly_ff, 2'h0, fs_do1_ff};
      `OTM_A_QSEL:    rd_data = {12'h0, qs_ao2_ff, 4'h0, qs_ao1_ff, 4'h0, qs_pls_ff};
      `OTM_A_PMAX:    rd_data = {18'h0, pmax_ff};
      `OTM_A_AO1:     rd_data = {off1_ff, gain1_ff};
      `OTM_A_AO2:     rd_data = {off2_ff, gain2_ff};
      `OTM_A_DLY_DO1: rd_data = {16'h0, dly_do1_ff};
      `OTM_A_DLY_RLY: rd_data = {16'h0, dly_rly_ff};
      `OTM_A_DLY_MUX: rd_data = {16'h0, dly_mux_ff};
      `OTM_A_POL:     rd_data = {15'h0, pol_ff};
      `OTM_A_TSET:    rd_data = {16'h0, tset_ff};
      `OTM_A_RTHR:    rd_data = {16'h0, rthr_ff};
      `OTM_A_AVILIM:  rd_data = {avi_hi_ff, avi_lo_ff};
      `OTM_A_TTHR:    rd_data = {16'h0, tthr_ff};
      `OTM_A_STAT:    rd_data = {2'h0, f10_ff, 9'h0, c_mux_ff, c_rly_ff, c_do1_ff,
                                 1'b0, d_mux, d_rly, d_do1};
      default:        rd_hit  = 1'b0;
    endcase
  end
  // read data is latched in the setup cycle so it comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= 1'b1;
      if (setup) begin
        prdata_ff  <= rd_data;
        pslverr_ff <= ~rd_hit;
      end
    end
  end
  // ========================================================
  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff      <= `OTM_MODE_PULSE;
      timing_en_ff <= 1'b0;
      fs_do1_ff    <= 6'h00;
      fs_rly_ff    <= 6'h00;
      fs_mux_ff    <= 6'h00;
      qs_pls_ff    <= 4'h0;
      qs_ao1_ff    <= 4'h0;
      qs_ao2_ff    <= 4'h0;
      pmax_ff      <= `OTM_PMAX_RST;
      gain1_ff     <= `OTM_GAIN_RST;
      off1_ff      <= 16'h0000;
      gain2_ff     <= `OTM_GAIN_RST;
      off2_ff      <= 16'h0000;
      dly_do1_ff   <= 16'h0000;
      dly_rly_ff   <= 16'h0000;
      dly_mux_ff   <= 16'h0000;
      pol_ff       <= 17'h00000;
      tset_ff      <= 16'h0000;
      rthr_ff      <= 16'h0000;
      avi_lo_ff    <= 16'h0000;
      avi_hi_ff    <= 16'hffff;
      tthr_ff      <= 16'hffff;
    end else if (wr) begin
      case (paddr)
        `OTM_A_CTRL: begin
          mode_ff      <= pwdata[`OTM_B_MODE];
          timing_en_ff <= pwdata[`OTM_B_TEN];
        end
        `OTM_A_FSEL: begin
          fs_do1_ff <= pwdata[`OTM_B_FS_DO1 +: 6];
          fs_rly_ff <= pwdata[`OTM_B_FS_RLY +: 6];
          fs_mux_ff <= pwdata[`OTM_B_FS_MUX +: 6];
        end
        `OTM_A_QSEL: begin
          qs_pls_ff <= pwdata[`OTM_B_QS_PLS +: 4];
          qs_ao1_ff <= pwdata[`OTM_B_QS_AO1 +: 4];
          qs_ao2_ff <= pwdata[`OTM_B_QS_AO2 +: 4];
        end
        // out-of-range maxima are clamped to the settable span
        `OTM_A_PMAX: begin
          if (pwdata[31:0] > {18'h0, `OTM_PMAX_MAX})
            pmax_ff <= `OTM_PMAX_MAX;
          else if (pwdata[13:0] < `OTM_PMAX_MIN)
            pmax_ff <= `OTM_PMAX_MIN;
          else
            pmax_ff <= pwdata[13:0];
        end
        `OTM_A_AO1: begin
          gain1_ff <= pwdata[15:0];
          off1_ff  <= pwdata[`OTM_B_HI +: 16];
        end
        `OTM_A_AO2: begin
          gain2_ff <= pwdata[15:0];
          off2_ff  <= pwdata[`OTM_B_HI +: 16];
        end
        `OTM_A_DLY_DO1: dly_do1_ff <= pwdata[15:0];
        `OTM_A_DLY_RLY: dly_rly_ff <= pwdata[15:0];
        `OTM_A_DLY_MUX: dly_mux_ff <= pwdata[15:0];
        `OTM_A_POL:     pol_ff     <= pwdata[16:0];
        `OTM_A_TSET:    tset_ff    <= pwdata[15:0];
        `OTM_A_RTHR:    rthr_ff    <= pwdata[15:0];
        `OTM_A_AVILIM: begin
          avi_lo_ff <= pwdata[15:0];
          avi_hi_ff <= pwdata[`OTM_B_HI +: 16];
        end
        `OTM_A_TTHR:    tthr_ff    <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  // ========================================================
  // shared serial divider: value * 1000 / full scale per channel
  // one divider serves three channels to save area; each result
  // refreshes every third pass, 81 cycles
  reg [1:0]  st_ff;
  reg [1:0]  ch_ff;
  reg [4:0]  step_ff;
  reg [25:0] num_ff;
  reg [16:0] den_ff;
  reg [16:0] rem_ff;
  reg [9:0]  frac_ff [0:2];
  reg [3:0]  ld_sel;
  reg [32:0] ld_q;
  wire [17:0] trial = {rem_ff, num_ff[25]};
  wire        qbit  = (trial >= {1'b0, den_ff});
  wire [25:0] quo   = {num_ff[24:0], qbit};
  always @* begin
    case (ch_ff)
      2'h0:    ld_sel = qs_pls_ff;
      2'h1:    ld_sel = qs_ao1_ff;
      default: ld_sel = qs_ao2_ff;
    endcase
    ld_q = otm_quant(ld_sel);
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff      <= ST_IDLE;
      ch_ff      <= 2'h0;
      step_ff    <= 5'h00;
      num_ff     <= 26'h0000000;
      den_ff     <= 17'h00000;
      rem_ff     <= 17'h00000;
      frac_ff[0] <= 10'h000;
      frac_ff[1] <= 10'h000;
      frac_ff[2] <= 10'h000;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          num_ff  <= {10'h000, ld_q[15:0]} * {16'h0000, `OTM_PERMIL};
          den_ff  <= ld_q[32:16];
          rem_ff  <= 17'h00000;
          step_ff <= 5'h00;
          st_ff   <= ST_RUN;
        end
        ST_RUN: begin
          num_ff <= quo;
          rem_ff <= qbit ? (trial[16:0] - den_ff) : trial[16:0];
          step_ff <= step_ff + 5'h01;
          if (step_ff == `OTM_DIV_STEPS) begin
            // zero reference gives zero; overrange saturates
            if (den_ff == 17'h00000)
              frac_ff[ch_ff] <= 10'h000;
            else if (quo > {16'h0000, `OTM_PERMIL})
              frac_ff[ch_ff] <= `OTM_PERMIL;
            else
              frac_ff[ch_ff] <= quo[9:0];
            ch_ff <= (ch_ff == 2'h2) ? 2'h0 : ch_ff + 2'h1;
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
  // ========================================================
  // pulse frequency generator (phase accumulator)
  reg [23:0] pls_prod_ff;
  reg [16:0] inc_ff;
  reg [23:0] acc_ff;
  wire [26:0] inc_prod = {13'h0000, f10_ff} * {14'h0000, `OTM_NCO_MUL};
  wire [23:0] f10_raw  = pls_prod_ff / {14'h0000, `OTM_PERMIL};
  // floor at the lowest settable frequency so the output never stalls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pls_prod_ff <= 24'h000000;
      f10_ff      <= `OTM_PMAX_MIN;
      inc_ff      <= 17'h00000;
      acc_ff      <= 24'h000000;
    end else begin
      pls_prod_ff <= {14'h0000, frac_ff[0]} * {10'h000, pmax_ff};
      f10_ff      <= (f10_raw[13:0] < `OTM_PMAX_MIN) ? `OTM_PMAX_MIN : f10_raw[13:0];
      inc_ff      <= inc_prod[`OTM_NCO_SH +: 17];
      acc_ff      <= acc_ff + {7'h00, inc_ff};
    end
  end
  // ========================================================
  // analog commands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_output_one_ff <= 10'h000;
      analog_output_two_ff <= 10'h000;
    end else begin
      analog_output_one_ff <= otm_scale(frac_ff[1], gain1_ff, off1_ff);
      analog_output_two_ff <= otm_scale(frac_ff[2], gain2_ff, off2_ff);
    end
  end
  // ========================================================
  // digital conditions and 0.1 s timebase
  reg [22:0] tick_cnt_ff;
  reg        tick_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_do1_ff    <= 1'b0;
      c_rly_ff    <= 1'b0;
      c_mux_ff    <= 1'b0;
      tick_cnt_ff <= 23'h000000;
      tick_ff     <= 1'b0;
    end else begin
      c_do1_ff <= otm_cond(fs_do1_ff);
      c_rly_ff <= otm_cond(fs_rly_ff);
      c_mux_ff <= (mode_ff != `OTM_MODE_PULSE) & otm_cond(fs_mux_ff);
      tick_ff  <= (tick_cnt_ff == TICK_CYC[22:0] - 23'h000001);
      if (tick_cnt_ff == TICK_CYC[22:0] - 23'h000001)
        tick_cnt_ff <= 23'h000000;
      else
        tick_cnt_ff <= tick_cnt_ff + 23'h000001;
    end
  end
  // ========================================================
  // delay stages
  otm_delay u_dly_do1 (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_ff),
    .dly     (dly_do1_ff),
    .din     (c_do1_ff),
    .dout_ff (d_do1)
  );
  otm_delay u_dly_rly (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_ff),
    .dly     (dly_rly_ff),
    .din     (c_rly_ff),
    .dout_ff (d_rly)
  );
  otm_delay u_dly_mux (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick_ff),
    .dly     (dly_mux_ff),
    .din     (c_mux_ff),
    .dout_ff (d_mux)
  );
  // ========================================================
  // polarity after the delay, then terminal drive
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_digital_output_ff        <= 1'b0;
      main_relay_output_ff           <= 1'b0;
      multiplexed_output_terminal_ff <= 1'b0;
    end else begin
      first_digital_output_ff <= d_do1 ^ otm_inv(`OTM_POL_D0);
      main_relay_output_ff    <= d_rly ^ otm_inv(`OTM_POL_D1);
      if (mode_ff == `OTM_MODE_PULSE)
        multiplexed_output_terminal_ff <= acc_ff[23];
      else
        multiplexed_output_terminal_ff <= d_mux ^ otm_inv(`OTM_POL_D4);
    end
  end
endmodule // otm_top
`default_nettype wire

/* tb/otm_checker.sv */
// Purpose: port assertions for otm_top
// Assumes: zero-wait apb slave
// Notes:   sees top ports only
`timescale 1ns/1ps
`default_nettype none
module otm_checker (
  // clock, reset, apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata_ff,
  input wire logic        pready_ff,
  input wire logic        pslverr_ff,
  // analog commands
  input wire logic [9:0]  analog_output_one_ff,
  input wire logic [9:0]  analog_output_two_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // apb phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  wire mapped = (paddr <= 8'h38) && (paddr[1:0] == 2'h0);
  // config reaches the mapper only through these
  chk_zero_wait: assert property (s_setup ##1 s_access |-> pready_ff)
    else $error("access not answered at once");
  chk_ready_up: assert property ($past(presetn) |-> pready_ff)
    else $error("ready low after reset");
  chk_err_unmap: assert property (psel && !penable && !mapped |=> pslverr_ff && prdata_ff == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (psel && !penable && mapped |=> !pslverr_ff)
    else $error("mapped access refused");
  chk_data_hold: assert property (!(psel && !penable) |=> $stable(prdata_ff))
    else $error("read data moved outside setup");
  chk_err_hold: assert property (!(psel && !penable) |=> $stable(pslverr_ff))
    else $error("error flag moved outside setup");
  // 1000 is the 10 v full scale of the command
  chk_ao_one_max: assert property (analog_output_one_ff <= 10'h3e8)
    else $error("first analog command above full scale");
  chk_ao_two_max: assert property (analog_output_two_ff <= 10'h3e8)
    else $error("second analog command above full scale");
endmodule // otm_checker
bind otm_top otm_checker u_chk (.*);
`default_nettype wire

/* tb/otm_load_model.sv */
// Purpose: pulse counter on the multiplexed terminal
// Assumes: terminal is a pclk flop
// Notes:   counts closings since clr
`timescale 1ns/1ps
`default_nettype none
module otm_load_model (
  // clock and watched contact
  input wire logic        pclk,
  input wire logic        terminal,
  input wire logic        clr,
  // closings counted
  output logic     [15:0] edges_ff
);
  logic last_ff = 1'b0;
  // each closing is one counted pulse
  always @(posedge pclk) begin
    last_ff <= terminal;
    if (clr)
      edges_ff <= 16'h0;
    else if (terminal && !last_ff)
      edges_ff <= edges_ff + 16'h1;
  end
endmodule // otm_load_model
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: directed test of otm_top
// Assumes: TICK_CYC 10, zero-wait apb
// Notes:   delays of a few ticks keep runs short
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
  logic load_drop = 1'b0, reverse_run = 1'b0, drive_running = 1'b1, fault_keep_run = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata_ff, r;
  logic pready_ff, pslverr_ff, first_digital_output_ff, main_relay_output_ff, multiplexed_output_terminal_ff;
  logic [9:0] analog_output_one_ff, analog_output_two_ff;
  logic [15:0] run_time = 16'h0, analog_input_one = 16'h000f, heatsink_temp = 16'h0, edges_ff;
  logic [15:0] run_freq = 16'h01f4, set_freq = 16'h00fa, lower_limit_freq = 16'h000a, max_freq = 16'h03e8;
  logic [15:0] out_current = 16'h01f4, rated_current = 16'h01f4, out_torque = 16'h00fa, rated_torque = 16'h00fa;
  logic [15:0] out_power = 16'h0064, rated_power = 16'h0064, out_voltage = 16'h0258, rated_voltage = 16'h03e8;
  logic [15:0] length_meas = 16'h00fa, length_max = 16'h01f4, count_val = 16'h0001, count_max = 16'h0004;
  int num_errors = 0, n_compared = 0;
  int codes[8] = '{30, 31, 32, 33, 35, 37, 38, 40};
  int qs[8] = '{0, 1, 2, 3, 4, 5, 10, 11};
  int qexp[8] = '{500, 250, 500, 500, 500, 500, 500, 250};
  // ==========================================
  // clock, design and pulse counter
  always #12.5 pclk = ~pclk;
  otm_top #(.TICK_CYC(10)) u_dut (.*);
  otm_load_model u_load (.pclk(pclk), .terminal(multiplexed_output_terminal_ff), .clr(clr), .edges_ff(edges_ff));
  // ==========================================
  // helpers
  task automatic stop_test;
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // apb cycle; idles one edge after so psel never toggles twice at once
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready_ff !== 1'b1 && i < 20);
    if (i >= 20) begin
      num_errors++;
      $display("[FAIL] %0t apb ready timeout", $time);
      stop_test();
    end
    r = prdata_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // drives one status condition true or just short of true
  task automatic cond(input int c, input logic on);
    case (c)
      30: run_time <= on ? 16'h0064 : 16'h0063;
      31: analog_input_one <= on ? 16'h0015 : 16'h000f;
      32: load_drop <= on;
      33: reverse_run <= on;
      35: heatsink_temp <= on ? 16'h0032 : 16'h0031;
      37: drive_running <= !on;
      38: fault_keep_run <= on;
      default: run_time <= on ? 16'h0065 : 16'h0064;
    endcase
  endtask
  // ==========================================
  // main sequence
  initial begin
    cyc(6);
    presetn <= 1'b1;
    cyc(2);
    rd(8'h0c, 32'h00001388);
    rd(8'h3c, 32'h0);
    chk({31'h0, pslverr_ff}, 32'h1);
    xfer(1'b1, 8'h00, 32'h2);
    xfer(1'b1, 8'h28, 32'h64);
    xfer(1'b1, 8'h2c, 32'h64);
    xfer(1'b1, 8'h30, 32'h0014000a);
    xfer(1'b1, 8'h34, 32'h32);
    foreach (codes[k]) begin
      xfer(1'b1, 8'h04, codes[k]);
      cond(codes[k], 1'b0);
      cyc(6);
      chk({31'h0, first_digital_output_ff}, 32'h0);
      cond(codes[k], 1'b1);
      cyc(6);
      chk({31'h0, first_digital_output_ff}, 32'h1);
      cond(codes[k], 1'b0);
    end
    // all three switched on reverse run, all negative logic
    xfer(1'b1, 8'h00, 32'h3);
    xfer(1'b1, 8'h04, 32'h00212121);
    xfer(1'b1, 8'h24, 32'h0000271b);
    cyc(6);
    chk({29'h0, first_digital_output_ff, main_relay_output_ff, multiplexed_output_terminal_ff}, 32'h7);
    cond(33, 1'b1);
    cyc(6);
    chk({29'h0, first_digital_output_ff, main_relay_output_ff, multiplexed_output_terminal_ff}, 32'h0);
    xfer(1'b1, 8'h24, 32'h0);
    cyc(1);
    chk({29'h0, first_digital_output_ff, main_relay_output_ff, multiplexed_output_terminal_ff}, 32'h7);
    xfer(1'b1, 8'h18, 32'h3);
    cond(33, 1'b0);
    cyc(6);
    chk({30'h0, first_digital_output_ff, main_relay_output_ff}, 32'h2);
    cyc(44);
    chk({31'h0, first_digital_output_ff}, 32'h0);
    cond(33, 1'b1);
    cyc(15);
    cond(33, 1'b0);
    cyc(50);
    chk({31'h0, first_digital_output_ff}, 32'h0);
    // scaled quantities on both analog commands
    xfer(1'b1, 8'h00, 32'h0);
    foreach (qs[k]) begin
      xfer(1'b1, 8'h08, (qs[k] << 8) | (qs[k] << 16));
      cyc(120);
      chk({22'h0, analog_output_one_ff}, qexp[k]);
      chk({22'h0, analog_output_two_ff}, qexp[k]);
    end
    xfer(1'b1, 8'h08, 32'h0);
    xfer(1'b1, 8'h10, 32'hff9c0096);
    xfer(1'b1, 8'h14, 32'h03e8ff9c);
    cyc(120);
    chk({22'h0, analog_output_one_ff}, 32'h28a);
    chk({22'h0, analog_output_two_ff}, 32'h1f4);
    // half scale is 1600 cycles a pulse at 50 khz, then 800 at 100 khz
    for (int p = 10; p <= 20; p += 10) begin
      cyc(200);
      clr <= 1'b1;
      cyc(1);
      clr <= 1'b0;
      cyc(16000);
      chk({31'h0, edges_ff >= p - 1 && edges_ff <= p + 1}, 32'h1);
      xfer(1'b1, 8'h0c, 32'h0);
      rd(8'h0c, 32'h1);
      xfer(1'b1, 8'h0c, 32'h4000);
      rd(8'h0c, 32'h2710);
    end
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
